// File: clsrb_top.v
// Climate sensor register bank behind a two-wire target port
`timescale 1ns/1ns
`include "clsrb_consts.vh"
module clsrb_top #(
	parameter CONV_CYC = `CONV_CYC
) (
	input wire CLK_SYS,
	input wire NRST,
	input wire CE,
	input wire SCL_IN,
	output reg SCL_OUT,
	output reg SCL_OE,
	input wire SDA_IN,
	output reg SDA_OUT,
	output reg SDA_OE,
	input wire [1:0] ADDR_STRAP_PIN,
	input wire SUPPLY_OK,
	input wire [15:0] TEMP_RAW,
	input wire [15:0] HUMID_RAW,
	input wire [15:0] SUPPLY_RAW,
	output reg HEATER_ON,
	output reg STANDBY,
	output reg ALARM_OUT_N,
	output wire ALARM_OE
);
	localparam [31:0] CONV_LAST32 = CONV_CYC - 1;
	localparam [20:0] CONV_LAST = CONV_LAST32[20:0];

	localparam [8:0] S_IDLE = 9'h001;
	localparam [8:0] S_ADDR = 9'h002;
	localparam [8:0] S_AACK = 9'h004;
	localparam [8:0] S_PTR = 9'h008;
	localparam [8:0] S_PACK = 9'h010;
	localparam [8:0] S_WDAT = 9'h020;
	localparam [8:0] S_WACK = 9'h040;
	localparam [8:0] S_RDAT = 9'h080;
	localparam [8:0] S_RACK = 9'h100;

	// ==========================================
	// Reset release and pin sampling
	reg rst_a_q;
	reg rst_b_q;
	wire rst_n;
	wire [4:0] pin_s;
	wire scl_s;
	wire sda_s;
	wire vok_s;
	reg scl_p_q;
	reg sda_p_q;
	reg [1:0] strap_q;
	reg [1:0] strap_age_q;

	always @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			rst_a_q <= 1'b0;
			rst_b_q <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_b_q <= rst_a_q;
		end
	end
	assign rst_n = rst_b_q;

	clsrb_sync #(
		.W(5)
	) u_sync (
		.clk(CLK_SYS),
		.rst_n(rst_n),
		.ce(CE),
		.d({SCL_IN, SDA_IN, SUPPLY_OK, ADDR_STRAP_PIN}),
		.q(pin_s)
	);
	assign scl_s = pin_s[4];
	assign sda_s = pin_s[3];
	assign vok_s = pin_s[2];

	// ==========================================
	// Register and compare state
	reg [15:0] setup_q;
	reg [15:0] limits_q;
	reg soft_reset_request_q;
	reg start_t_q;
	reg start_h_q;
	reg wr_q;
	reg [15:0] wdat_q;
	reg [7:0] ptr_q;
	wire busy;
	wire [15:0] temp_r;
	wire [15:0] humid_r;
	wire [15:0] supply_r;
	wire t_alm;
	wire h_alm;
	wire alarm;
	wire [15:0] setup_rd;
	reg [15:0] rd_mux;
	wire [6:0] my_addr;

	clsrb_meas #(
		.CONV_LAST(CONV_LAST)
	) u_meas (
		.clk(CLK_SYS),
		.rst_n(rst_n),
		.ce(CE),
		.clr(soft_reset_request_q),
		.start_t(start_t_q),
		.start_h(start_h_q),
		.mode(setup_q[`B_MODE]),
		.vmeas_on(setup_q[`B_VMEAS]),
		.tres(setup_q[`B_TRES]),
		.hres(setup_q[`B_HRES_HI:`B_HRES_LO]),
		.atrig(setup_q[`B_ATRIG_HI:`B_ATRIG_LO]),
		.limits(limits_q),
		.temp_raw(TEMP_RAW),
		.humid_raw(HUMID_RAW),
		.supply_raw(SUPPLY_RAW),
		.busy(busy),
		.temp_q(temp_r),
		.humid_q(humid_r),
		.supply_q(supply_r),
		.t_alm_q(t_alm),
		.h_alm_q(h_alm),
		.alarm_q(alarm)
	);
	// Open-drain alarm: pulled low while the alarm stands
	assign ALARM_OE = alarm;

	// Status bits merged live; bit 15 never stored
	assign setup_rd = {1'b0, setup_q[14:12], vok_s, setup_q[10:6],
		alarm, h_alm, t_alm, setup_q[2], 2'h0};

	always @* begin
		case (ptr_q)
		`REG_TEMP: rd_mux = temp_r;
		`REG_HUMID: rd_mux = humid_r;
		`REG_SETUP: rd_mux = setup_rd;
		`REG_LIMITS: rd_mux = limits_q;
		`REG_SUPPLY: rd_mux = supply_r;
		`REG_MAKER: rd_mux = `MAKER_ID;
		`REG_REV: rd_mux = `REV_ID;
		default: rd_mux = 16'h0000;
		endcase
	end

	// Strap caught once; sync pipe shows reset zeros for two cycles
	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			strap_q <= 2'h0;
			strap_age_q <= 2'h0;
		end else if (CE && strap_age_q != 2'h3) begin
			strap_age_q <= strap_age_q + 2'h1;
			if (strap_age_q == 2'h2)
				strap_q <= pin_s[1:0];
		end
	end
	assign my_addr = `ADDR_BASE + {5'h00, strap_q};

	// ==========================================
	// Register writes and soft reset
	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			setup_q <= `SETUP_RST;
			limits_q <= `LIMITS_RST;
			soft_reset_request_q <= 1'b0;
		end else if (CE) begin
			soft_reset_request_q <= 1'b0;
			if (soft_reset_request_q) begin
				setup_q <= `SETUP_RST;
				limits_q <= `LIMITS_RST;
			end else if (wr_q) begin
				if (ptr_q == `REG_SETUP) begin
					setup_q <= wdat_q & `SETUP_WMASK;
					soft_reset_request_q <= wdat_q[`B_SOFT_RESET_REQUEST];
				end else if (ptr_q == `REG_LIMITS) begin
					limits_q <= wdat_q;
				end
				// Other indices: acked, contents untouched
			end
		end
	end

	// ==========================================
	// Two-wire target engine
	reg [8:0] st_q;
	reg [7:0] sh_q;
	reg [3:0] bcnt_q;
	reg [7:0] hi_q;
	reg [7:0] tx_q;
	reg [15:0] rd_q;
	reg bidx_q;
	reg rw_q;
	reg hack_q;
	wire scl_rise;
	wire scl_fall;
	wire bus_start;
	wire bus_stop;

	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;
	assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			st_q <= S_IDLE;
			sh_q <= 8'h00;
			bcnt_q <= 4'h0;
			ptr_q <= 8'h00;
			hi_q <= 8'h00;
			tx_q <= 8'h00;
			rd_q <= 16'h0000;
			bidx_q <= 1'b0;
			rw_q <= 1'b0;
			hack_q <= 1'b0;
			wdat_q <= 16'h0000;
			wr_q <= 1'b0;
			start_t_q <= 1'b0;
			start_h_q <= 1'b0;
			SDA_OE <= 1'b0;
			SCL_OE <= 1'b0;
			STANDBY <= 1'b1;
		end else if (CE) begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			start_t_q <= 1'b0;
			start_h_q <= 1'b0;
			wr_q <= 1'b0;
			if (bus_start) begin
				st_q <= S_ADDR;
				bcnt_q <= 4'h0;
				SDA_OE <= 1'b0;
				SCL_OE <= 1'b0;
				STANDBY <= 1'b0;
			end else if (bus_stop) begin
				st_q <= S_IDLE;
				SDA_OE <= 1'b0;
				SCL_OE <= 1'b0;
			end else begin
				case (st_q)
				S_IDLE: st_q <= S_IDLE;
				S_ADDR, S_PTR, S_WDAT: begin
					if (scl_rise) begin
						sh_q <= {sh_q[6:0], sda_s};
						bcnt_q <= bcnt_q + 4'h1;
					end else if (scl_fall && bcnt_q == 4'h8) begin
						bcnt_q <= 4'h0;
						if (st_q == S_ADDR) begin
							if (sh_q[7:1] != my_addr) begin
								st_q <= S_IDLE;
							end else if (sh_q[0] && busy &&
								!setup_q[`B_STRETCH]) begin
								st_q <= S_IDLE;
							end else begin
								rw_q <= sh_q[0];
								bidx_q <= 1'b0;
								SDA_OE <= 1'b1;
								SCL_OE <= sh_q[0] & busy;
								st_q <= S_AACK;
							end
						end else if (st_q == S_PTR) begin
							ptr_q <= sh_q;
							SDA_OE <= 1'b1;
							st_q <= S_PACK;
							start_t_q <= (sh_q == `REG_TEMP);
							start_h_q <= (sh_q == `REG_HUMID);
						end else begin
							SDA_OE <= 1'b1;
							st_q <= S_WACK;
							if (!bidx_q) begin
								hi_q <= sh_q;
								bidx_q <= 1'b1;
							end else begin
								wdat_q <= {hi_q, sh_q};
								wr_q <= 1'b1;
								bidx_q <= 1'b0;
							end
						end
					end
				end
				S_AACK: begin
					// Hold the clock low until conversion ends
					if (SCL_OE) begin
						if (!busy)
							SCL_OE <= 1'b0;
					end else if (scl_fall) begin
						bcnt_q <= 4'h0;
						if (rw_q) begin
							rd_q <= rd_mux;
							tx_q <= rd_mux[15:8];
							SDA_OE <= ~rd_mux[15];
							st_q <= S_RDAT;
						end else begin
							SDA_OE <= 1'b0;
							st_q <= S_PTR;
						end
					end
				end
				S_PACK, S_WACK: begin
					if (scl_fall) begin
						SDA_OE <= 1'b0;
						bcnt_q <= 4'h0;
						if (st_q == S_PACK)
							bidx_q <= 1'b0;
						st_q <= S_WDAT;
					end
				end
				S_RDAT: begin
					if (scl_fall) begin
						bcnt_q <= bcnt_q + 4'h1;
						if (bcnt_q == 4'h7) begin
							SDA_OE <= 1'b0;
							st_q <= S_RACK;
						end else begin
							SDA_OE <= ~tx_q[6];
							tx_q <= {tx_q[6:0], 1'b0};
						end
					end
				end
				S_RACK: begin
					if (scl_rise) begin
						hack_q <= ~sda_s;
					end else if (scl_fall) begin
						bcnt_q <= 4'h0;
						// Snapshot keeps both bytes of one word
						if (hack_q && !bidx_q) begin
							bidx_q <= 1'b1;
							tx_q <= rd_q[7:0];
							SDA_OE <= ~rd_q[7];
							st_q <= S_RDAT;
						end else begin
							st_q <= S_IDLE;
						end
					end
				end
				default: st_q <= S_IDLE;
				endcase
			end
		end
	end

	// ==========================================
	// Static pin levels and heater drive
	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			SCL_OUT <= 1'b0;
			SDA_OUT <= 1'b0;
			ALARM_OUT_N <= 1'b0;
			HEATER_ON <= 1'b0;
		end else if (CE) begin
			SCL_OUT <= 1'b0;
			SDA_OUT <= 1'b0;
			ALARM_OUT_N <= 1'b0;
			HEATER_ON <= setup_q[`B_HEAT];
		end
	end
endmodule // clsrb_top

// File: clsrb_consts.vh
// Constants for the climate sensor register bank
`ifndef CLSRB_CONSTS_VH
`define CLSRB_CONSTS_VH
// ==========================================
// Register indices
`define REG_TEMP 8'h00
`define REG_HUMID 8'h01
`define REG_SETUP 8'h02
`define REG_LIMITS 8'h03
`define REG_SUPPLY 8'h04
`define REG_MAKER 8'hFE
`define REG_REV 8'hFF
// ==========================================
// Setup word layout and reset
`define SETUP_RST 16'h1000
`define SETUP_WMASK 16'h77C4
`define B_SOFT_RESET_REQUEST 15
`define B_STRETCH 14
`define B_HEAT 13
`define B_MODE 12
`define B_TRES 10
`define B_HRES_HI 9
`define B_HRES_LO 8
`define B_ATRIG_HI 7
`define B_ATRIG_LO 6
`define B_VMEAS 2
`define LIMITS_RST 16'h0000
// Identity values, arbitrary
`define MAKER_ID 16'h1234
`define REV_ID 16'h0001
// ==========================================
// Result masks per resolution
`define MASK14 16'hFFFC
`define MASK11 16'hFFE0
`define MASK8 16'hFF00
// ==========================================
// Target address, strap adds 0..3
`define ADDR_BASE 7'h40
// ==========================================
// Timing
`define CLK_PERIOD_NS 4
`define CONV_TIME_NS 6500000
`define CONV_CYC (`CONV_TIME_NS / `CLK_PERIOD_NS)
`endif

// File: clsrb_sync.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module clsrb_sync #(
	parameter W = 1
) (
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {W{1'b0}};
			q <= {W{1'b0}};
		end else if (ce) begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // clsrb_sync

// File: clsrb_meas.v
// Conversion sequencer, result capture and limit compare
`timescale 1ns/1ns
`include "clsrb_consts.vh"
module clsrb_meas #(
	parameter [20:0] CONV_LAST = 21'h0_0000
) (
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire clr,
	input wire start_t,
	input wire start_h,
	input wire mode,
	input wire vmeas_on,
	input wire tres,
	input wire [1:0] hres,
	input wire [1:0] atrig,
	input wire [15:0] limits,
	input wire [15:0] temp_raw,
	input wire [15:0] humid_raw,
	input wire [15:0] supply_raw,
	output wire busy,
	output reg [15:0] temp_q,
	output reg [15:0] humid_q,
	output reg [15:0] supply_q,
	output reg t_alm_q,
	output reg h_alm_q,
	output reg alarm_q
);
	localparam [2:0] M_IDLE = 3'h1;
	localparam [2:0] M_T = 3'h2;
	localparam [2:0] M_H = 3'h4;

	reg [2:0] st_q;
	reg [20:0] cnt_q;
	reg cmp_q;
	wire [15:0] tmask;
	wire [15:0] hmask;
	wire t_hit;
	wire h_hit;
	reg alarm_d;

	assign busy = ~st_q[0];
	assign tmask = tres ? `MASK11 : `MASK14;
	assign hmask = (hres == 2'h2) ? `MASK8 :
		(hres == 2'h1) ? `MASK11 : `MASK14;
	// Limit word: humidity in top 7 bits, temperature in low 9
	assign t_hit = temp_q >= {limits[8:0], 7'h00};
	assign h_hit = humid_q >= {limits[15:9], 9'h000};

	always @* begin
		case (atrig)
		2'h0: alarm_d = t_hit | h_hit;
		2'h1: alarm_d = t_hit;
		2'h2: alarm_d = h_hit;
		default: alarm_d = t_hit & h_hit;
		endcase
	end

	// ==========================================
	// Sequencer
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= M_IDLE;
			cnt_q <= 21'h0_0000;
			cmp_q <= 1'b0;
			temp_q <= 16'h0000;
			humid_q <= 16'h0000;
			supply_q <= 16'h0000;
			t_alm_q <= 1'b0;
			h_alm_q <= 1'b0;
			alarm_q <= 1'b0;
		end else if (ce) begin
			cmp_q <= 1'b0;
			if (clr) begin
				st_q <= M_IDLE;
				cnt_q <= 21'h0_0000;
				temp_q <= 16'h0000;
				humid_q <= 16'h0000;
				supply_q <= 16'h0000;
				t_alm_q <= 1'b0;
				h_alm_q <= 1'b0;
				alarm_q <= 1'b0;
			end else begin
				case (st_q)
				M_IDLE: begin
					cnt_q <= 21'h0_0000;
					if (start_t)
						st_q <= M_T;
					else if (start_h)
						st_q <= M_H;
				end
				M_T: begin
					if (cnt_q == CONV_LAST) begin
						temp_q <= temp_raw & tmask;
						cnt_q <= 21'h0_0000;
						if (mode) begin
							st_q <= M_H;
						end else begin
							st_q <= M_IDLE;
							cmp_q <= 1'b1;
						end
					end else begin
						cnt_q <= cnt_q + 21'h0_0001;
					end
				end
				M_H: begin
					if (cnt_q == CONV_LAST) begin
						humid_q <= humid_raw & hmask;
						st_q <= M_IDLE;
						cmp_q <= 1'b1;
					end else begin
						cnt_q <= cnt_q + 21'h0_0001;
					end
				end
				default: st_q <= M_IDLE;
				endcase
				// Compare a cycle late so fresh results are used
				if (cmp_q) begin
					t_alm_q <= t_hit;
					h_alm_q <= h_hit;
					alarm_q <= alarm_d;
					if (vmeas_on)
						supply_q <= supply_raw;
				end
			end
		end
	end
endmodule // clsrb_meas

// File: clsrb_chk_assertions.sv
// Port-level assertions for the climate sensor register bank
`timescale 1ns/1ns
module clsrb_chk #(
	parameter CONV_CYC = 16
) (
	input wire CLK_SYS,
	input wire NRST,
	input wire SCL_IN,
	input wire SCL_OUT,
	input wire SCL_OE,
	input wire SDA_IN,
	input wire SDA_OUT,
	input wire SDA_OE,
	input wire HEATER_ON,
	input wire STANDBY,
	input wire ALARM_OUT_N,
	input wire ALARM_OE
);
// Two conversions plus slack for a stretched read
localparam int SMAX = 2 * CONV_CYC + 64;
reg scl_q;
reg sda_q;
reg start_q;
// ==========
// Raw-pin start detector, ahead of the synchroniser
always @(posedge CLK_SYS or negedge NRST) begin
	if (!NRST) begin
		scl_q <= 1'b1;
		sda_q <= 1'b1;
		start_q <= 1'b0;
	end else begin
		scl_q <= SCL_IN;
		sda_q <= SDA_IN;
		if (scl_q && SCL_IN && sda_q && !SDA_IN) begin
			start_q <= 1'b1;
		end
	end
end
// ==========
// Properties
default clocking cb @(posedge CLK_SYS);
endclocking
default disable iff (!NRST);
property p_od_low;
	!SCL_OUT && !SDA_OUT && !ALARM_OUT_N;
endproperty
a_od_low: assert property (p_od_low)
	else $error("open-drain value driven high");
property p_rst_state;
	$rose(NRST) |-> STANDBY && !HEATER_ON && !ALARM_OE && !SDA_OE && !SCL_OE;
endproperty
a_rst_state: assert property (p_rst_state)
	else $error("outputs not at reset state");
property p_stby_once;
	!$rose(STANDBY);
endproperty
a_stby_once: assert property (p_stby_once)
	else $error("standby re-entered");
property p_stby_start;
	$fell(STANDBY) |-> start_q;
endproperty
a_stby_start: assert property (p_stby_start)
	else $error("standby left without bus start");
// Data may only move while the clock is low
property p_sda_hold;
	SCL_IN [*6] |-> $stable(SDA_OE);
endproperty
a_sda_hold: assert property (p_sda_hold)
	else $error("data line moved while clock high");
property p_stretch;
	$rose(SCL_OE) |-> ##[1:SMAX] !SCL_OE;
endproperty
a_stretch: assert property (p_stretch)
	else $error("clock held past conversion");
property p_heat;
	$changed(HEATER_ON) |-> !STANDBY;
endproperty
a_heat: assert property (p_heat)
	else $error("heater moved before bus traffic");
property p_alarm;
	ALARM_OE |-> !STANDBY;
endproperty
a_alarm: assert property (p_alarm)
	else $error("alarm without measurement");
endmodule // clsrb_chk

bind clsrb_top clsrb_chk #(.CONV_CYC(CONV_CYC)) clsrb_chk_i (
	.CLK_SYS(CLK_SYS), .NRST(NRST), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT),
	.SCL_OE(SCL_OE), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
	.HEATER_ON(HEATER_ON), .STANDBY(STANDBY), .ALARM_OUT_N(ALARM_OUT_N),
	.ALARM_OE(ALARM_OE)
);

// File: clsrb_host.sv
// Two-wire host model for the bank's serial port
`timescale 1ns/1ns
module clsrb_host (
	input wire scl,
	input wire sda,
	output logic scl_o,
	output logic sda_o
);
logic [6:0] dev;
initial begin
	scl_o = 1'b1;
	sda_o = 1'b1;
	dev = 7'h43;
end
// ==========
// Bit level; released lines float to the pull-up
task automatic bt(input logic b, output logic r);
	int n;
	n = 0;
	#8 sda_o = b;
	#8 scl_o = 1'b1;
	while (!scl && n < 4000) begin
		#4 n++;
	end
	#16 r = sda;
	scl_o = 1'b0;
endtask
task automatic start();
	#8 sda_o = 1'b1;
	#16 scl_o = 1'b1;
	#16 sda_o = 1'b0;
	#16 scl_o = 1'b0;
endtask
task automatic stop();
	#8 sda_o = 1'b0;
	#8 scl_o = 1'b1;
	#16 sda_o = 1'b1;
	#16;
endtask
task automatic wb(input logic [7:0] d, output logic ack);
	logic r;
	for (int i = 7; i >= 0; i--) begin
		bt(d[i], r);
	end
	bt(1'b1, r);
	ack = !r;
endtask
task automatic rb(input logic last, output logic [7:0] d);
	logic r;
	for (int i = 7; i >= 0; i--) begin
		bt(1'b1, d[i]);
	end
	bt(last, r);
endtask
// ==========
// Transactions
task automatic trig(input logic [7:0] idx, output logic ok);
	logic a0;
	logic a1;
	start();
	wb({dev, 1'b0}, a0);
	wb(idx, a1);
	stop();
	ok = a0 & a1;
endtask
task automatic wr(input logic [7:0] idx, input logic [15:0] v, output logic ok);
	logic a0;
	logic a1;
	logic a2;
	logic a3;
	start();
	wb({dev, 1'b0}, a0);
	wb(idx, a1);
	wb(v[15:8], a2);
	wb(v[7:0], a3);
	stop();
	ok = a0 & a1 & a2 & a3;
endtask
task automatic rd(input logic [7:0] idx, output logic [15:0] v, output logic ok);
	logic a0;
	logic a1;
	logic a2;
	v = 16'h0000;
	start();
	wb({dev, 1'b0}, a0);
	wb(idx, a1);
	start();
	wb({dev, 1'b1}, a2);
	if (a2) begin
		rb(1'b0, v[15:8]);
		rb(1'b1, v[7:0]);
	end
	stop();
	ok = a0 & a1 & a2;
endtask
endmodule // clsrb_host

// File: clsrb_tb.sv
// Self-checking bench for the climate sensor register bank
`timescale 1ns/1ns
`include "clsrb_consts.vh"
module testbench;
localparam int CC = 400;
logic CLK_SYS = 1'b0;
logic NRST = 1'b0;
logic SUPPLY_OK = 1'b1;
logic [15:0] TEMP_RAW = 16'h1237;
logic [15:0] HUMID_RAW = 16'h5A5F;
wire SCL_OE, SDA_OE, HEATER_ON, STANDBY, ALARM_OE, scl_o, sda_o;
wire scl = scl_o & ~SCL_OE;
wire sda = sda_o & ~SDA_OE;
int fails = 0;
int samples_checked = 0;
int cyc = 0;
logic [15:0] w;
logic ok;
always #2 CLK_SYS = ~CLK_SYS;
clsrb_top #(.CONV_CYC(CC)) clsrb_top_i (
	.CLK_SYS(CLK_SYS), .NRST(NRST), .CE(1'b1), .SCL_IN(scl), .SCL_OUT(),
	.SCL_OE(SCL_OE), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(SDA_OE),
	.ADDR_STRAP_PIN(2'b11), .SUPPLY_OK(SUPPLY_OK), .TEMP_RAW(TEMP_RAW),
	.HUMID_RAW(HUMID_RAW), .SUPPLY_RAW(16'h9C41), .HEATER_ON(HEATER_ON),
	.STANDBY(STANDBY), .ALARM_OUT_N(), .ALARM_OE(ALARM_OE)
);
clsrb_host clsrb_host_i (.scl(scl), .sda(sda), .scl_o(scl_o), .sda_o(sda_o));
task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
	samples_checked++;
	if (g !== e) begin
		fails++;
		$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
	end
endtask
task automatic report_and_stop();
	$display("checks %0d mismatches %0d", samples_checked, fails);
	if (fails == 0 && samples_checked > 0) begin
		$display("STATUS OK");
	end else begin
		$display("STATUS NOT OK");
	end
	$finish;
endtask
// ==========
// Scenarios
task automatic t_reset();
	logic [7:0] ix [6];
	logic [15:0] ex [6];
	ix = '{`REG_SETUP, `REG_LIMITS, `REG_SUPPLY, `REG_MAKER, `REG_REV, 8'h10};
	ex = '{16'h1800, 16'h0000, 16'h0000, `MAKER_ID, `REV_ID, 16'h0000};
	chk(16'(STANDBY), 16'h0001, "standby");
	for (int i = 0; i < 6; i++) begin
		clsrb_host_i.rd(ix[i], w, ok);
		chk(w, ex[i], "reset value");
	end
	chk(16'(STANDBY), 16'h0000, "standby left");
	clsrb_host_i.dev = 7'h40;
	clsrb_host_i.trig(`REG_SETUP, ok);
	clsrb_host_i.dev = 7'h43;
	chk(16'(ok), 16'h0000, "foreign address");
	$display("test reset done");
endtask
task automatic t_setup();
	clsrb_host_i.wr(`REG_LIMITS, 16'hABCD, ok);
	clsrb_host_i.wr(`REG_SETUP, 16'h7FFF, ok);
	clsrb_host_i.rd(`REG_SETUP, w, ok);
	chk(w, `SETUP_WMASK | 16'h0800, "setup");
	chk(16'(HEATER_ON), 16'h0001, "heater");
	SUPPLY_OK = 1'b0;
	clsrb_host_i.rd(`REG_SETUP, w, ok);
	chk(w, `SETUP_WMASK, "supply flag");
	clsrb_host_i.wr(`REG_SUPPLY, 16'hFFFF, ok);
	chk(16'(ok), 16'h0001, "ro write ack");
	clsrb_host_i.rd(`REG_SUPPLY, w, ok);
	chk(w, 16'h0000, "ro kept");
	clsrb_host_i.wr(`REG_SETUP, 16'h8000, ok);
	clsrb_host_i.rd(`REG_SETUP, w, ok);
	chk(w, `SETUP_RST, "soft reset");
	clsrb_host_i.rd(`REG_LIMITS, w, ok);
	chk(w, 16'h0000, "limits cleared");
	chk(16'(HEATER_ON), 16'h0000, "heater off");
	SUPPLY_OK = 1'b1;
	$display("test setup done");
endtask
// Temp stays under its limit, humidity over; each code seen once
task automatic t_meas();
	logic [15:0] cfg;
	logic [15:0] hm;
	clsrb_host_i.wr(`REG_LIMITS, 16'h01FF, ok);
	for (int i = 3; i >= 0; i--) begin
		cfg = {4'b0101, 1'b0, i[0], i[1:0], i[1:0], 6'b000100};
		hm = HUMID_RAW & (i == 2 ? `MASK8 : i == 1 ? `MASK11 : `MASK14);
		clsrb_host_i.wr(`REG_SETUP, cfg, ok);
		clsrb_host_i.trig(`REG_TEMP, ok);
		repeat (2 * CC + 40) @(negedge CLK_SYS);
		clsrb_host_i.rd(`REG_SETUP, w, ok);
		cfg = cfg | 16'h0810 | (i[0] ? 16'h0000 : 16'h0020);
		chk(w, cfg, "flags");
		chk(16'(ALARM_OE), 16'(!i[0]), "alarm pin");
		clsrb_host_i.rd(`REG_SUPPLY, w, ok);
		chk(w, 16'h9C41, "supply result");
		clsrb_host_i.rd(`REG_TEMP, w, ok);
		chk(w, TEMP_RAW & (i[0] ? `MASK11 : `MASK14), "temp");
		clsrb_host_i.rd(`REG_HUMID, w, ok);
		chk(w, hm, "humid");
	end
	$display("test measure done");
endtask
task automatic t_mode0();
	TEMP_RAW = 16'hFFFF;
	HUMID_RAW = 16'h0123;
	clsrb_host_i.wr(`REG_SETUP, 16'h0000, ok);
	clsrb_host_i.trig(`REG_HUMID, ok);
	clsrb_host_i.rd(`REG_SETUP, w, ok);
	chk(16'(ok), 16'h0000, "busy read refused");
	repeat (CC + 40) @(negedge CLK_SYS);
	clsrb_host_i.rd(`REG_SETUP, w, ok);
	chk(w, 16'h0830, "humidity only");
	clsrb_host_i.wr(`REG_SETUP, 16'h8000, ok);
	chk(16'(ALARM_OE), 16'h0000, "alarm cleared");
	$display("test mode0 done");
endtask
// ==========
// Sequence and hang guard
always @(posedge CLK_SYS) begin
	cyc++;
	if (cyc == 80000) begin
		fails++;
		$display("CHECK FAILED t=%0t timeout", $time);
		report_and_stop();
	end
end
initial begin
	repeat (4) @(negedge CLK_SYS);
	NRST = 1'b1;
	repeat (10) @(negedge CLK_SYS);
	t_reset();
	t_setup();
	t_meas();
	t_mode0();
	report_and_stop();
end
endmodule // testbench
